// [common/etsr_pkg.sv]
// Package of constants for the event timestamp record block
package etsr_pkg;
   localparam int NUM_BYTES = 9;
   localparam int REC0_BYTES = 7;
   // Register indices
   localparam int IDX_S0_SEC = 0;
   localparam int IDX_S0_MIN = 1;
   localparam int IDX_S0_HOUR = 2;
   localparam int IDX_S0_DATE = 3;
   localparam int IDX_S0_MONTH = 4;
   localparam int IDX_S0_YEAR = 5;
   localparam int IDX_S0_FLAGS = 6;
   localparam int IDX_S1_SUBSEC = 7;
   localparam int IDX_S1_SEC = 8;
   // Byte addresses, index 8 first
   localparam logic [8:0][7:0] REG_ADDR = {8'h29, 8'h28, 8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21};
   // Implemented bits of each byte
   localparam logic [8:0][7:0] REG_MASK = {8'h7f, 8'h7f, 8'h0f, 8'hff, 8'h9f, 8'h3f, 8'h7f, 8'h7f, 8'h7f};
   localparam logic [8:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Field positions
   localparam int SEC_TENS_LSB = 4;
   localparam int HOUR_FMT_BIT = 6;
   localparam int HOUR_MER_BIT = 5;
   localparam int HOUR_TENS_BIT = 4;
   localparam int FLAG_LOW_VOLTAGE = 3;
   localparam int FLAG_TO_BACKUP = 2;
   localparam int FLAG_TO_MAIN = 1;
   localparam int FLAG_EVENT_PIN = 0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] FLAG_PAD = 4'h0;
endpackage : etsr_pkg

// [tb/etsr_host_model.sv]
// Host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module etsr_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata,
   output logic o_rd
);
   initial begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
      o_rd = 1'b0;
   end
   // One byte write, held until the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask : wr
   // One byte read, bounded wait for valid
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         @(posedge i_clk);
         if (i_rvalid === 1'b1) begin
            d = i_rdata;
            break;
         end
      end
   endtask : rd
   // Write, then read the same byte on the next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
      d = 8'hxx;
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= wd;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         @(posedge i_clk);
         if (i_rvalid === 1'b1) begin
            d = i_rdata;
            break;
         end
      end
   endtask : wr_rd
endmodule : etsr_host_model
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the event timestamp record block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; $display("unexpected %0t got %h exp %h", $time, a, e); end end
module tb_top;
   typedef struct packed {logic [3:0] cause; logic [7:0] sec, hr, esec, ehr, eflg;} etsr_row_t;
   logic clk;
   logic rst_n;
   logic cap;
   logic rec;
   logic [3:0] cause;
   logic [7:0] now [7];
   wire logic [7:0] addr, wdata, rdata;
   wire logic wr, rd, rvalid;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int oth [4] = '{1, 3, 4, 5};
   etsr_row_t rows [4] = '{
      '{4'h8, 8'hd9, 8'h23, 8'h59, 8'h23, 8'h08},
      '{4'h4, 8'h00, 8'h72, 8'h00, 8'h72, 8'h04},
      '{4'h2, 8'h30, 8'h41, 8'h30, 8'h41, 8'h02},
      '{4'h1, 8'hc5, 8'h99, 8'h45, 8'h19, 8'h01}};
   etsr_records uut (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
      .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_CAP_TRIG(cap), .I_CAP_RECORD(rec),
      .I_LOW_VOLTAGE_DETECT(cause[3]), .I_TO_BACKUP(cause[2]), .I_TO_MAIN(cause[1]), .I_EVENT_PIN(cause[0]),
      .I_NOW_SUBSEC(now[0]), .I_NOW_SEC(now[1]), .I_NOW_MIN(now[2]), .I_NOW_HOUR(now[3]),
      .I_NOW_DATE(now[4]), .I_NOW_MONTH(now[5]), .I_NOW_YEAR(now[6]));
   etsr_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr), .o_wr(wr),
      .o_wdata(wdata), .o_rd(rd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic capture(input logic r, input logic [3:0] c, input logic [7:0] s, h, f);
      @(posedge clk);
      cap <= 1'b1;
      rec <= r;
      cause <= c;
      now <= '{f, s, f, h, f, f, f};
      @(posedge clk);
      cap <= 1'b0;
   endtask : capture
   task automatic chk_rd(input int i, input logic [7:0] e);
      logic [7:0] d;
      host.rd(etsr_pkg::REG_ADDR[i], d);
      `CHK(d, e)
   endtask : chk_rd
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      logic [7:0] d;
      rst_n = 1'b0;
      cap = 1'b0;
      rec = 1'b0;
      cause = 4'h0;
      now = '{default: 8'h00};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[r]) begin
         capture(1'b0, rows[r].cause, rows[r].sec, rows[r].hr, 8'hf0 | 8'(r));
         chk_rd(etsr_pkg::IDX_S0_SEC, rows[r].esec);
         chk_rd(etsr_pkg::IDX_S0_HOUR, rows[r].ehr);
         chk_rd(etsr_pkg::IDX_S0_FLAGS, rows[r].eflg);
         foreach (oth[k]) chk_rd(oth[k], (8'hf0 | 8'(r)) & etsr_pkg::REG_MASK[oth[k]]);
      end
      $display("test capture rows done");
      capture(1'b1, 4'hf, 8'h59, 8'h00, 8'hff);
      chk_rd(etsr_pkg::IDX_S1_SUBSEC, 8'h7f);
      chk_rd(etsr_pkg::IDX_S1_SEC, 8'h59);
      chk_rd(etsr_pkg::IDX_S0_FLAGS, 8'h01);
      $display("test record one done");
      fork
         host.wr(etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_SEC], 8'h11);
         capture(1'b0, 4'h8, 8'h37, 8'h12, 8'h00);
      join
      chk_rd(etsr_pkg::IDX_S0_SEC, 8'h37);
      $display("test capture wins done");
      for (int i = 0; i < etsr_pkg::NUM_BYTES; i++) host.wr(etsr_pkg::REG_ADDR[i], 8'hff);
      for (int i = 0; i < etsr_pkg::NUM_BYTES; i++) chk_rd(i, etsr_pkg::REG_MASK[i]);
      host.wr(8'h2a, 8'hff);
      host.rd(8'h2a, d);
      `CHK(d, etsr_pkg::UNMAPPED_READ)
      host.wr_rd(etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_FLAGS], 8'hf5, d);
      `CHK(d, 8'h05)
      $display("test host access done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(rdata, 8'h00)
      `CHK(rvalid, 1'b0)
      rst_n <= 1'b1;
      for (int i = 0; i < etsr_pkg::NUM_BYTES; i++) chk_rd(i, etsr_pkg::REG_RESET[i]);
      $display("test reset done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire

// [verilog/etsr_byte_reg.sv]
// One record byte with host write and capture load
`timescale 1ns/1ps
`default_nettype none
module etsr_byte_reg #(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wdata,
   input wire logic i_cap_en,
   input wire logic [7:0] i_cap_data,
   output logic [7:0] o_q
);
   typedef struct packed {
      logic [7:0] value;
   } etsr_byte_state_t;

   etsr_byte_state_t state;
   etsr_byte_state_t next_state;

   always_comb begin
      next_state = state;
      if (i_cap_en) begin
         next_state.value = i_cap_data & MASK;
      end else if (i_wr_en) begin
         next_state.value = i_wdata & MASK;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= '{value: RESET_VAL};
      end else begin
         state <= next_state;
      end
   end

   assign o_q = state.value;
endmodule : etsr_byte_reg
`default_nettype wire

// [verilog/etsr_records.sv]
// Event timestamp record storage with register port and capture
`timescale 1ns/1ps
`default_nettype none
module etsr_records (
   input wire logic I_REF_CLK,
   input wire logic I_RESETN,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_REG_RD,
   output logic [7:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   input wire logic I_CAP_TRIG,
   input wire logic I_CAP_RECORD,
   input wire logic I_LOW_VOLTAGE_DETECT,
   input wire logic I_TO_BACKUP,
   input wire logic I_TO_MAIN,
   input wire logic I_EVENT_PIN,
   input wire logic [7:0] I_NOW_SUBSEC,
   input wire logic [7:0] I_NOW_SEC,
   input wire logic [7:0] I_NOW_MIN,
   input wire logic [7:0] I_NOW_HOUR,
   input wire logic [7:0] I_NOW_DATE,
   input wire logic [7:0] I_NOW_MONTH,
   input wire logic [7:0] I_NOW_YEAR
);
   typedef struct packed {
      logic [7:0] rdata;
      logic rvalid;
   } etsr_state_t;

   etsr_state_t state;
   etsr_state_t next_state;
   logic [7:0] stamp [etsr_pkg::NUM_BYTES];
   logic [7:0] cap_data [etsr_pkg::NUM_BYTES];
   logic [etsr_pkg::NUM_BYTES-1:0] cap_en;
   logic [etsr_pkg::NUM_BYTES-1:0] wr_en;
   logic [3:0] cause;
   logic cap0;
   logic cap1;

   assign cap0 = I_CAP_TRIG && !I_CAP_RECORD;
   assign cap1 = I_CAP_TRIG && I_CAP_RECORD;

   // Cause byte: each bit set only by its own event
   always_comb begin
      cause = 4'h0;
      cause[etsr_pkg::FLAG_LOW_VOLTAGE] = I_LOW_VOLTAGE_DETECT;
      cause[etsr_pkg::FLAG_TO_BACKUP] = I_TO_BACKUP;
      cause[etsr_pkg::FLAG_TO_MAIN] = I_TO_MAIN;
      cause[etsr_pkg::FLAG_EVENT_PIN] = I_EVENT_PIN;
   end

   // Capture sources; hour byte keeps format, meridiem/twenties and tens
   always_comb begin
      cap_data[etsr_pkg::IDX_S0_SEC] = I_NOW_SEC;
      cap_data[etsr_pkg::IDX_S0_MIN] = I_NOW_MIN;
      cap_data[etsr_pkg::IDX_S0_HOUR] = I_NOW_HOUR;
      cap_data[etsr_pkg::IDX_S0_DATE] = I_NOW_DATE;
      cap_data[etsr_pkg::IDX_S0_MONTH] = I_NOW_MONTH;
      cap_data[etsr_pkg::IDX_S0_YEAR] = I_NOW_YEAR;
      cap_data[etsr_pkg::IDX_S0_FLAGS] = {etsr_pkg::FLAG_PAD, cause};
      cap_data[etsr_pkg::IDX_S1_SUBSEC] = I_NOW_SUBSEC;
      cap_data[etsr_pkg::IDX_S1_SEC] = I_NOW_SEC;
   end

   // All bytes of one record load in the same cycle
   always_comb begin
      for (int i = 0; i < etsr_pkg::NUM_BYTES; i++) begin
         cap_en[i] = (i < etsr_pkg::REC0_BYTES) ? cap0 : cap1;
         wr_en[i] = I_REG_WR && (I_REG_ADDR == etsr_pkg::REG_ADDR[i]);
      end
   end

   genvar g;
   generate
      for (g = 0; g < etsr_pkg::NUM_BYTES; g++) begin : g_byte
         etsr_byte_reg #(
            .MASK(etsr_pkg::REG_MASK[g]),
            .RESET_VAL(etsr_pkg::REG_RESET[g])
         ) u_byte (
            .i_clk(I_REF_CLK),
            .i_resetn(I_RESETN),
            .i_wr_en(wr_en[g]),
            .i_wdata(I_REG_WDATA),
            .i_cap_en(cap_en[g]),
            .i_cap_data(cap_data[g]),
            .o_q(stamp[g])
         );
      end
   endgenerate

   // Registered read port; unmapped addresses read zero
   always_comb begin
      next_state = state;
      next_state.rvalid = I_REG_RD;
      if (I_REG_RD) begin
         next_state.rdata = etsr_pkg::UNMAPPED_READ;
         for (int i = 0; i < etsr_pkg::NUM_BYTES; i++) begin
            if (I_REG_ADDR == etsr_pkg::REG_ADDR[i]) begin
               next_state.rdata = stamp[i];
            end
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= '{rdata: 8'h00, rvalid: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign O_REG_RDATA = state.rdata;
   assign O_REG_RVALID = state.rvalid;

   // Checks
   a_sec_layout: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_SEC] == {1'b0, $past(I_NOW_SEC[6:0])})
      else $error("seconds byte not captured with bit 7 clear");
   a_hour_24h: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap0 && !I_NOW_HOUR[etsr_pkg::HOUR_FMT_BIT]) |=> !stamp[etsr_pkg::IDX_S0_HOUR][etsr_pkg::HOUR_FMT_BIT])
      else $error("24-hour format lost on capture");
   a_hour_12h: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap0 && I_NOW_HOUR[etsr_pkg::HOUR_FMT_BIT]) |=> stamp[etsr_pkg::IDX_S0_HOUR][etsr_pkg::HOUR_FMT_BIT])
      else $error("12-hour format lost on capture");
   a_hour_meridiem: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_HOUR][etsr_pkg::HOUR_MER_BIT] == $past(I_NOW_HOUR[5]))
      else $error("meridiem or twenties bit wrong");
   a_hour_twenties: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap0 && !I_NOW_HOUR[etsr_pkg::HOUR_FMT_BIT])
         |=> stamp[etsr_pkg::IDX_S0_HOUR][etsr_pkg::HOUR_MER_BIT] == $past(I_NOW_HOUR[etsr_pkg::HOUR_MER_BIT]))
      else $error("twenties digit lost on capture");
   a_hour_digits: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_HOUR][4:0] == $past(I_NOW_HOUR[4:0]))
      else $error("hour tens or units wrong");
   a_flag_low_volt: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_FLAGS][etsr_pkg::FLAG_LOW_VOLTAGE] == $past(I_LOW_VOLTAGE_DETECT))
      else $error("low voltage flag wrong");
   a_flag_backup: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_FLAGS][etsr_pkg::FLAG_TO_BACKUP] == $past(I_TO_BACKUP))
      else $error("to backup flag wrong");
   a_flag_main: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_FLAGS][etsr_pkg::FLAG_TO_MAIN] == $past(I_TO_MAIN))
      else $error("to main flag wrong");
   a_flag_event: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_FLAGS][etsr_pkg::FLAG_EVENT_PIN] == $past(I_EVENT_PIN))
      else $error("event pin flag wrong");
   a_flag_pad: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_FLAGS][7:4] == etsr_pkg::FLAG_PAD)
      else $error("flag byte pad bits not clear");
   a_min_capture: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_MIN] == ($past(I_NOW_MIN) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_MIN]))
      else $error("minutes byte not captured");
   a_date_capture: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_DATE] == ($past(I_NOW_DATE) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_DATE]))
      else $error("date byte not captured");
   a_month_capture: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_MONTH] == ($past(I_NOW_MONTH) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_MONTH]))
      else $error("month byte not captured");
   a_year_capture: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      cap0 |=> stamp[etsr_pkg::IDX_S0_YEAR] == ($past(I_NOW_YEAR) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_YEAR]))
      else $error("year byte not captured");
   a_rec0_atomic: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap0 && !I_REG_WR) |=> $stable(stamp[etsr_pkg::IDX_S1_SEC]) && $stable(stamp[etsr_pkg::IDX_S1_SUBSEC]))
      else $error("record zero capture touched record one");
   a_rec1_atomic: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap1 && !I_REG_WR)
         |=> stamp[etsr_pkg::IDX_S1_SEC] == ($past(I_NOW_SEC) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S1_SEC])
         && stamp[etsr_pkg::IDX_S1_SUBSEC] == ($past(I_NOW_SUBSEC) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S1_SUBSEC])
         && $stable(stamp[etsr_pkg::IDX_S0_SEC]))
      else $error("record one capture not atomic");
   a_cap_beats_wr: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cap0 && I_REG_WR && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_SEC])
         |=> stamp[etsr_pkg::IDX_S0_SEC] == ($past(I_NOW_SEC) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_SEC]))
      else $error("host write beat capture");

   // Register port read and write checks
   a_read_back: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_WR && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_FLAGS] && !I_CAP_TRIG)
         ##1 (I_REG_RD && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_FLAGS])
         |=> O_REG_RVALID && O_REG_RDATA == ($past(I_REG_WDATA, 2) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S0_FLAGS]))
      else $error("flag byte read back wrong");
   a_read_mapped: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_RD && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_HOUR])
         |=> O_REG_RDATA == $past(stamp[etsr_pkg::IDX_S0_HOUR]))
      else $error("hour byte read data wrong");
   a_rvalid_pulse: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      I_REG_RD |=> O_REG_RVALID)
      else $error("read not answered next cycle");
   a_rvalid_idle: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_REG_RD |=> !O_REG_RVALID)
      else $error("read valid without a read");
   a_rdata_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_REG_RD |=> $stable(O_REG_RDATA))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_RD && (I_REG_ADDR < etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_SEC]
         || I_REG_ADDR > etsr_pkg::REG_ADDR[etsr_pkg::IDX_S1_SEC]))
         |=> O_REG_RDATA == etsr_pkg::UNMAPPED_READ)
      else $error("unmapped address did not read zero");
   a_write_lands: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_WR && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S0_YEAR] && !I_CAP_TRIG)
         |=> stamp[etsr_pkg::IDX_S0_YEAR] == $past(I_REG_WDATA))
      else $error("host write to year byte lost");
   a_rec1_wr_lands: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_WR && I_REG_ADDR == etsr_pkg::REG_ADDR[etsr_pkg::IDX_S1_SUBSEC] && !I_CAP_TRIG)
         |=> stamp[etsr_pkg::IDX_S1_SUBSEC] == ($past(I_REG_WDATA) & etsr_pkg::REG_MASK[etsr_pkg::IDX_S1_SUBSEC]))
      else $error("host write to sub-second byte lost");
   a_wr_elsewhere: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_REG_WR && I_REG_ADDR > etsr_pkg::REG_ADDR[etsr_pkg::IDX_S1_SEC] && !I_CAP_TRIG)
         |=> $stable(stamp[etsr_pkg::IDX_S1_SEC]) && $stable(stamp[etsr_pkg::IDX_S0_SEC]))
      else $error("unmapped write changed a byte");
endmodule : etsr_records
`default_nettype wire
